// File: logic/cbf_pkg.sv
package cbf_pkg;

  // Register map, byte addresses of aligned 32-bit words
  localparam int         ADR_W      = 8;
  localparam logic [7:0] ADR_INSTR  = 8'h00;
  localparam logic [7:0] ADR_STATUS = 8'h04;
  localparam logic [7:0] ADR_FLAGS  = 8'h08;
  localparam logic [7:0] ADR_PC     = 8'h0c;
  localparam logic [7:0] ADR_IDX    = 8'h10;
  localparam logic [7:0] ADR_GPR    = 8'h14;
  localparam logic [7:0] ADR_MEM    = 8'h18;
  localparam logic [7:0] ADR_IO     = 8'h1c;

  // Status register fields
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_CYC_LSB  = 8;

  // Status flag positions
  localparam int FLG_C = 0;
  localparam int FLG_Z = 1;
  localparam int FLG_N = 2;
  localparam int FLG_V = 3;
  localparam int FLG_S = 4;
  localparam int FLG_H = 5;
  localparam int FLG_T = 6;
  localparam int FLG_I = 7;

  // Reset values
  localparam logic [7:0]  FLAGS_RST = 8'h00;
  localparam logic [15:0] PC_RST    = 16'h0000;
  localparam logic [15:0] INSTR_RST = 16'h0000;
  localparam logic [7:0]  GPR_RST   = 8'h00;
  localparam logic [7:0]  IO_RST    = 8'h00;
  localparam logic [7:0]  IDX_RST   = 8'h00;

  // Execution lengths in clock cycles
  localparam logic [1:0] CYC_ONE = 2'h1;
  localparam logic [1:0] CYC_TWO = 2'h2;

  // Instruction word fields
  localparam int         OPC_LSB     = 11;
  localparam int         K_W         = 7;
  localparam int         IOA_LSB     = 3;
  localparam int         REGB_LSB    = 3;
  localparam int         PAIRD_LSB   = 4;
  localparam int         PTR_SEL_BIT = 5;
  localparam int         MODE_LSB    = 6;
  localparam logic [4:0] PTR_X_LO    = 5'h1a;
  localparam logic [4:0] PTR_Y_LO    = 5'h1c;

  typedef enum logic [4:0] {
    OP_NOP                = 5'h00,
    OP_BRANCH_IRQ_ON      = 5'h01,
    OP_BRANCH_IRQ_OFF     = 5'h02,
    OP_IO_BIT_SET         = 5'h03,
    OP_IO_BIT_CLEAR       = 5'h04,
    OP_SHIFT_LEFT_LOGICAL = 5'h05,
    OP_SHIFT_RIGHT_LOGICAL= 5'h06,
    OP_SHIFT_RIGHT_ARITH  = 5'h07,
    OP_ROTATE_LEFT_CARRY  = 5'h08,
    OP_ROTATE_RIGHT_CARRY = 5'h09,
    OP_NIBBLE_SWAP        = 5'h0a,
    OP_FLAG_SET           = 5'h0b,
    OP_FLAG_CLEAR         = 5'h0c,
    OP_BIT_TO_T_FLAG      = 5'h0d,
    OP_T_FLAG_TO_BIT      = 5'h0e,
    OP_COPY_REGISTER_PAIR = 5'h0f,
    OP_LOAD_INDIRECT      = 5'h10
  } cbf_op_t;

  typedef enum logic [1:0] {
    LDM_PLAIN    = 2'h0,
    LDM_POST_INC = 2'h1,
    LDM_PRE_DEC  = 2'h2
  } cbf_ldmode_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EX1  = 2'b01,
    ST_EX2  = 2'b11
  } cbf_state_t;

  typedef enum logic [2:0] {
    SH_LEFT, SH_RIGHT, SH_ARITH, SH_ROT_L, SH_ROT_R, SH_SWAP
  } cbf_shop_t;

endpackage

// File: logic/cbf_regbus_if.sv
`timescale 1ns/1ps
interface cbf_regbus_if #(parameter int AW = 8);
  logic          req;
  logic          we;
  logic [AW-1:0] adr;
  logic [31:0]   wdat;
  logic [3:0]    sel;
  logic [31:0]   rdat;
  modport slave (output req, we, adr, wdat, sel, input rdat);
  modport core  (input req, we, adr, wdat, sel, output rdat);
endinterface

// File: logic/cbf_wb_slave.sv
`timescale 1ns/1ps
module cbf_wb_slave #(
  parameter int AW = 8
) (
  // Clock and reset
  input  wire logic          core_clk_in,
  input  wire logic          nrst_in,
  // Wishbone classic slave
  input  wire logic          wb_cyc_in,
  input  wire logic          wb_stb_in,
  input  wire logic          wb_we_in,
  input  wire logic [AW-1:0] wb_adr_in,
  input  wire logic [31:0]   wb_dat_in,
  input  wire logic [3:0]    wb_sel_in,
  output logic               wb_ack_out,
  output logic [31:0]        wb_dat_out,
  // Register side
  cbf_regbus_if.slave        bus
);
  logic        ack_q;
  logic [31:0] dat_q;

  // One request per cycle, dropped while ack is up so a held strobe is not replayed
  assign bus.req  = wb_cyc_in & wb_stb_in & ~ack_q;
  assign bus.we   = wb_we_in;
  assign bus.adr  = wb_adr_in;
  assign bus.wdat = wb_dat_in;
  assign bus.sel  = wb_sel_in;

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= bus.req;
    end
  end

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      dat_q <= 32'h0000_0000;
    end else if (bus.req && !wb_we_in) begin
      dat_q <= bus.rdat;
    end
  end

  assign wb_ack_out = ack_q;
  assign wb_dat_out = dat_q;
endmodule

// File: logic/cbf_shift_unit.sv
`timescale 1ns/1ps
module cbf_shift_unit
  import cbf_pkg::*;
(
  // Operation
  input  wire cbf_shop_t  op_in,
  input  wire logic [7:0] val_in,
  input  wire logic       c_in,
  // Result and flags
  output logic [7:0]      res_out,
  output logic            c_out,
  output logic            z_out,
  output logic            n_out,
  output logic            v_out
);
  always_comb begin
    res_out = val_in;
    c_out   = c_in;
    case (op_in)
      SH_LEFT: begin
        res_out = {val_in[6:0], 1'b0};
        c_out   = val_in[7];
      end
      SH_RIGHT: begin
        res_out = {1'b0, val_in[7:1]};
        c_out   = val_in[0];
      end
      SH_ARITH: begin
        res_out = {val_in[7], val_in[7:1]};
        c_out   = val_in[0];
      end
      SH_ROT_L: begin
        res_out = {val_in[6:0], c_in};
        c_out   = val_in[7];
      end
      SH_ROT_R: begin
        res_out = {c_in, val_in[7:1]};
        c_out   = val_in[0];
      end
      SH_SWAP: begin
        res_out = {val_in[3:0], val_in[7:4]};
      end
      default: begin
        res_out = val_in;
      end
    endcase
    z_out = (res_out == 8'h00);
    n_out = res_out[7];
    // Overflow after a shift is sign change, i.e. N xor C
    v_out = res_out[7] ^ c_out;
  end
endmodule

// File: logic/cbf_core_top.sv
// Implementation choices: the register offsets and the Wishbone register port.
`timescale 1ns/1ps
module cbf_core_top
  import cbf_pkg::*;
#(
  parameter int PC_W    = 12,
  parameter int DMEM_AW = 8
) (
  // Clock and reset
  input  wire logic             core_clk_in,
  input  wire logic             nrst_in,
  // Wishbone classic slave
  input  wire logic             wb_cyc_in,
  input  wire logic             wb_stb_in,
  input  wire logic             wb_we_in,
  input  wire logic [ADR_W-1:0] wb_adr_in,
  input  wire logic [31:0]      wb_dat_in,
  input  wire logic [3:0]       wb_sel_in,
  output logic                  wb_ack_out,
  output logic [31:0]           wb_dat_out,
  // Core state
  output logic                  busy_out,
  output logic [7:0]            io_port0_out
);
  cbf_regbus_if #(.AW(ADR_W)) rbus ();

  cbf_state_t         state_q;
  logic [15:0]        instr_q;
  logic [PC_W-1:0]    pc_q;
  logic [7:0]         flags_q;
  logic [7:0]         idx_q;
  logic [1:0]         cyc_last_q;
  logic [7:0]         gpr_q  [32];
  logic [7:0]         io_q   [32];
  logic [7:0]         dmem_q [2**DMEM_AW];

  cbf_op_t            op;
  cbf_ldmode_t        ptr_upd;
  cbf_shop_t          sh_op;
  logic [4:0]         f_d;
  logic [4:0]         f_rb;
  logic [4:0]         f_io;
  logic [2:0]         f_bit;
  logic [4:0]         pair_d;
  logic [4:0]         pair_r;
  logic [K_W-1:0]     f_k;
  logic [4:0]         ptr_lo;
  logic [15:0]        ptr_val;
  logic [7:0]         mem_rd;
  logic               taken;
  logic               two_cyc;
  logic               is_shift;
  logic               idle;
  logic               ex1;
  logic               ex2;
  logic               wr;
  logic               wr_lo;
  logic               wr_w;
  logic               launch;
  logic [7:0]         sh_res;
  logic               sh_c;
  logic               sh_z;
  logic               sh_n;
  logic               sh_v;

  function automatic logic [7:0] bit_mask(input logic [2:0] b);
    bit_mask = 8'h01 << b;
  endfunction

  function automatic logic [PC_W-1:0] branch_target(input logic [PC_W-1:0] pc,
                                                    input logic [K_W-1:0]  k);
    branch_target = pc + {{(PC_W-K_W){k[K_W-1]}}, k} + 1'b1;
  endfunction

  function automatic logic [4:0] pair_base(input logic [3:0] p);
    pair_base = {p, 1'b0};
  endfunction

  cbf_wb_slave #(.AW(ADR_W)) u_wb (
    .core_clk_in (core_clk_in),
    .nrst_in     (nrst_in),
    .wb_cyc_in   (wb_cyc_in),
    .wb_stb_in   (wb_stb_in),
    .wb_we_in    (wb_we_in),
    .wb_adr_in   (wb_adr_in),
    .wb_dat_in   (wb_dat_in),
    .wb_sel_in   (wb_sel_in),
    .wb_ack_out  (wb_ack_out),
    .wb_dat_out  (wb_dat_out),
    .bus         (rbus.slave)
  );

  // Instruction decode
  assign op      = cbf_op_t'(instr_q[15:OPC_LSB]);
  assign ptr_upd = cbf_ldmode_t'(instr_q[MODE_LSB+1:MODE_LSB]);
  assign f_d     = instr_q[4:0];
  assign f_rb    = instr_q[REGB_LSB+4:REGB_LSB];
  assign f_io    = instr_q[IOA_LSB+4:IOA_LSB];
  assign f_bit   = instr_q[2:0];
  assign pair_d  = pair_base(instr_q[PAIRD_LSB+3:PAIRD_LSB]);
  assign pair_r  = pair_base(instr_q[3:0]);
  assign f_k     = instr_q[K_W-1:0];
  assign ptr_lo  = instr_q[PTR_SEL_BIT] ? PTR_Y_LO : PTR_X_LO;
  assign ptr_val = {gpr_q[ptr_lo + 5'h01], gpr_q[ptr_lo]};
  assign mem_rd  = dmem_q[ptr_val[DMEM_AW-1:0]];

  assign taken   = (op == OP_BRANCH_IRQ_ON  &&  flags_q[FLG_I]) ||
                   (op == OP_BRANCH_IRQ_OFF && !flags_q[FLG_I]);
  assign two_cyc = taken || op == OP_IO_BIT_SET || op == OP_IO_BIT_CLEAR ||
                   op == OP_LOAD_INDIRECT;
  assign is_shift = op inside {OP_SHIFT_LEFT_LOGICAL, OP_SHIFT_RIGHT_LOGICAL,
                               OP_SHIFT_RIGHT_ARITH, OP_ROTATE_LEFT_CARRY,
                               OP_ROTATE_RIGHT_CARRY};

  assign idle   = (state_q == ST_IDLE);
  assign ex1    = (state_q == ST_EX1);
  assign ex2    = (state_q == ST_EX2);
  assign wr     = rbus.req && rbus.we;
  assign wr_lo  = wr && rbus.sel[0];
  assign wr_w   = wr && (rbus.sel[1:0] == 2'b11);
  // A new instruction is refused while one is running
  assign launch = wr_w && idle && rbus.adr == ADR_INSTR;

  always_comb begin
    case (op)
      OP_SHIFT_LEFT_LOGICAL:  sh_op = SH_LEFT;
      OP_SHIFT_RIGHT_LOGICAL: sh_op = SH_RIGHT;
      OP_SHIFT_RIGHT_ARITH:   sh_op = SH_ARITH;
      OP_ROTATE_LEFT_CARRY:   sh_op = SH_ROT_L;
      OP_ROTATE_RIGHT_CARRY:  sh_op = SH_ROT_R;
      default:                sh_op = SH_SWAP;
    endcase
  end

  cbf_shift_unit u_sh (
    .op_in   (sh_op),
    .val_in  (gpr_q[f_d]),
    .c_in    (flags_q[FLG_C]),
    .res_out (sh_res),
    .c_out   (sh_c),
    .z_out   (sh_z),
    .n_out   (sh_n),
    .v_out   (sh_v)
  );

  // Sequencer: one cycle in EX1, a second in EX2 for two-cycle work
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_q <= ST_IDLE;
      instr_q <= INSTR_RST;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (launch) begin
            state_q <= ST_EX1;
            instr_q <= rbus.wdat[15:0];
          end
        end
        ST_EX1:  state_q <= two_cyc ? ST_EX2 : ST_IDLE;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cyc_last_q <= 2'h0;
    end else if (ex1) begin
      cyc_last_q <= CYC_ONE;
    end else if (ex2) begin
      cyc_last_q <= CYC_TWO;
    end
  end

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pc_q <= PC_RST[PC_W-1:0];
    end else if (idle && wr_w && rbus.adr == ADR_PC) begin
      pc_q <= rbus.wdat[PC_W-1:0];
    end else if (ex1 && !taken) begin
      pc_q <= pc_q + 1'b1;
    end else if (ex2 && taken) begin
      pc_q <= branch_target(pc_q, f_k);
    end
  end

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      flags_q <= FLAGS_RST;
    end else if (idle && wr_lo && rbus.adr == ADR_FLAGS) begin
      flags_q <= rbus.wdat[7:0];
    end else if (ex1) begin
      if (is_shift) begin
        flags_q[FLG_C] <= sh_c;
        flags_q[FLG_Z] <= sh_z;
        flags_q[FLG_N] <= sh_n;
        flags_q[FLG_V] <= sh_v;
      end else if (op == OP_FLAG_SET) begin
        flags_q[f_bit] <= 1'b1;
      end else if (op == OP_FLAG_CLEAR) begin
        flags_q[f_bit] <= 1'b0;
      end else if (op == OP_BIT_TO_T_FLAG) begin
        flags_q[FLG_T] <= gpr_q[f_rb][f_bit];
      end
    end
  end

  // Working registers; a load into a pointer register overrides the pointer update
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      for (int i = 0; i < 32; i++) begin
        gpr_q[i] <= GPR_RST;
      end
    end else if (idle && wr_lo && rbus.adr == ADR_GPR) begin
      gpr_q[idx_q[4:0]] <= rbus.wdat[7:0];
    end else if (ex1) begin
      if (is_shift || op == OP_NIBBLE_SWAP) begin
        gpr_q[f_d] <= sh_res;
      end else if (op == OP_T_FLAG_TO_BIT) begin
        gpr_q[f_rb][f_bit] <= flags_q[FLG_T];
      end else if (op == OP_COPY_REGISTER_PAIR) begin
        gpr_q[pair_d]         <= gpr_q[pair_r];
        gpr_q[pair_d + 5'h01] <= gpr_q[pair_r + 5'h01];
      end else if (op == OP_LOAD_INDIRECT && ptr_upd == LDM_PRE_DEC) begin
        {gpr_q[ptr_lo + 5'h01], gpr_q[ptr_lo]} <= ptr_val - 16'h0001;
      end
    end else if (ex2 && op == OP_LOAD_INDIRECT) begin
      if (ptr_upd == LDM_POST_INC) begin
        {gpr_q[ptr_lo + 5'h01], gpr_q[ptr_lo]} <= ptr_val + 16'h0001;
      end
      gpr_q[f_d] <= mem_rd;
    end
  end

  // Data memory is written only from the bus; no reset, contents start undefined
  always_ff @(posedge core_clk_in) begin
    if (idle && wr_lo && rbus.adr == ADR_MEM) begin
      dmem_q[idx_q[DMEM_AW-1:0]] <= rbus.wdat[7:0];
    end
  end

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      for (int i = 0; i < 32; i++) begin
        io_q[i] <= IO_RST;
      end
    end else if (idle && wr_lo && rbus.adr == ADR_IO) begin
      io_q[idx_q[4:0]] <= rbus.wdat[7:0];
    end else if (ex2 && op == OP_IO_BIT_SET) begin
      io_q[f_io] <= io_q[f_io] | bit_mask(f_bit);
    end else if (ex2 && op == OP_IO_BIT_CLEAR) begin
      io_q[f_io] <= io_q[f_io] & ~bit_mask(f_bit);
    end
  end

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      idx_q <= IDX_RST;
    end else if (wr_lo && rbus.adr == ADR_IDX) begin
      idx_q <= rbus.wdat[7:0];
    end
  end

  always_comb begin
    rbus.rdat = 32'h0000_0000;
    if (rbus.adr == ADR_INSTR) begin
      rbus.rdat[15:0] = instr_q;
    end else if (rbus.adr == ADR_STATUS) begin
      rbus.rdat[STAT_BUSY_BIT]                = ~idle;
      rbus.rdat[STAT_CYC_LSB+1:STAT_CYC_LSB] = cyc_last_q;
    end else if (rbus.adr == ADR_FLAGS) begin
      rbus.rdat[7:0] = flags_q;
    end else if (rbus.adr == ADR_PC) begin
      rbus.rdat[PC_W-1:0] = pc_q;
    end else if (rbus.adr == ADR_IDX) begin
      rbus.rdat[7:0] = idx_q;
    end else if (rbus.adr == ADR_GPR) begin
      rbus.rdat[7:0] = gpr_q[idx_q[4:0]];
    end else if (rbus.adr == ADR_MEM) begin
      rbus.rdat[7:0] = dmem_q[idx_q[DMEM_AW-1:0]];
    end else if (rbus.adr == ADR_IO) begin
      rbus.rdat[7:0] = io_q[idx_q[4:0]];
    end
  end

  assign busy_out     = state_q[0];
  assign io_port0_out = io_q[0];

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!nrst_in);

  property p_branch_on;
    ex1 && op == OP_BRANCH_IRQ_ON && flags_q[FLG_I] |=> ex2 ##1
      (idle && pc_q == branch_target($past(pc_q, 2), f_k) && flags_q == $past(flags_q, 2));
  endproperty
  a_branch_on: assert property (p_branch_on) else $error("taken branch target wrong");

  property p_branch_off;
    ex1 && op == OP_BRANCH_IRQ_OFF && flags_q[FLG_I] |=>
      idle && pc_q == $past(pc_q) + 1'b1 && cyc_last_q == CYC_ONE;
  endproperty
  a_branch_off: assert property (p_branch_off) else $error("untaken branch wrong");

  property p_io_set;
    ex1 && op == OP_IO_BIT_SET |=> ##1
      idle && io_q[f_io] == ($past(io_q[f_io], 2) | bit_mask(f_bit));
  endproperty
  a_io_set: assert property (p_io_set) else $error("io bit set wrong");

  property p_io_clear;
    ex1 && op == OP_IO_BIT_CLEAR |=> ##1
      io_q[f_io] == ($past(io_q[f_io], 2) & ~bit_mask(f_bit)) && flags_q == $past(flags_q, 2);
  endproperty
  a_io_clear: assert property (p_io_clear) else $error("io bit clear wrong");

  property p_shl;
    ex1 && op == OP_SHIFT_LEFT_LOGICAL |=> idle &&
      gpr_q[f_d] == {$past(gpr_q[f_d][6:0]), 1'b0} && flags_q[FLG_C] == $past(gpr_q[f_d][7]);
  endproperty
  a_shl: assert property (p_shl) else $error("logical left shift wrong");

  property p_shr;
    ex1 && op == OP_SHIFT_RIGHT_LOGICAL |=> gpr_q[f_d][7] == 1'b0 &&
      gpr_q[f_d][6:0] == $past(gpr_q[f_d][7:1]) && flags_q[FLG_N] == 1'b0;
  endproperty
  a_shr: assert property (p_shr) else $error("logical right shift wrong");

  property p_asr;
    ex1 && op == OP_SHIFT_RIGHT_ARITH |=> gpr_q[f_d] == {$past(gpr_q[f_d][7]),
      $past(gpr_q[f_d][7:1])} && flags_q[FLG_C] == $past(gpr_q[f_d][0]);
  endproperty
  a_asr: assert property (p_asr) else $error("arithmetic shift wrong");

  property p_rot_l;
    ex1 && op == OP_ROTATE_LEFT_CARRY |=> gpr_q[f_d][0] == $past(flags_q[FLG_C]) &&
      flags_q[FLG_C] == $past(gpr_q[f_d][7]) && flags_q[FLG_V] == (gpr_q[f_d][7] ^ flags_q[FLG_C]);
  endproperty
  a_rot_l: assert property (p_rot_l) else $error("rotate left wrong");

  property p_rot_r;
    ex1 && op == OP_ROTATE_RIGHT_CARRY |=> gpr_q[f_d][7] == $past(flags_q[FLG_C]) &&
      flags_q[FLG_C] == $past(gpr_q[f_d][0]) && flags_q[FLG_Z] == (gpr_q[f_d] == 8'h00);
  endproperty
  a_rot_r: assert property (p_rot_r) else $error("rotate right wrong");

  property p_flag_set;
    ex1 && op == OP_FLAG_SET |=> idle && flags_q == ($past(flags_q) | bit_mask(f_bit));
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag set wrong");

  property p_to_t;
    ex1 && op == OP_BIT_TO_T_FLAG |=> flags_q[FLG_T] == $past(gpr_q[f_rb][f_bit]) &&
      flags_q[5:0] == $past(flags_q[5:0]) && flags_q[FLG_I] == $past(flags_q[FLG_I]);
  endproperty
  a_to_t: assert property (p_to_t) else $error("bit to T wrong");

  property p_from_t;
    ex1 && op == OP_T_FLAG_TO_BIT |=> gpr_q[f_rb][f_bit] == flags_q[FLG_T] &&
      flags_q == $past(flags_q);
  endproperty
  a_from_t: assert property (p_from_t) else $error("T to bit wrong");

  property p_load_post;
    ex1 && op == OP_LOAD_INDIRECT && ptr_upd == LDM_POST_INC && f_d[4:1] != ptr_lo[4:1] |=> ##1
      idle && gpr_q[f_d] == $past(mem_rd) && ptr_val == $past(ptr_val, 2) + 16'h0001;
  endproperty
  a_load_post: assert property (p_load_post) else $error("post-increment load wrong");

  property p_load_pre;
    ex1 && op == OP_LOAD_INDIRECT && ptr_upd == LDM_PRE_DEC && f_d[4:1] != ptr_lo[4:1] |=> ##1
      ptr_val == $past(ptr_val, 2) - 16'h0001 && gpr_q[f_d] == dmem_q[ptr_val[DMEM_AW-1:0]];
  endproperty
  a_load_pre: assert property (p_load_pre) else $error("pre-decrement load wrong");

  property p_swap;
    ex1 && op == OP_NIBBLE_SWAP |=> gpr_q[f_d] == {$past(gpr_q[f_d][3:0]),
      $past(gpr_q[f_d][7:4])} && flags_q == $past(flags_q);
  endproperty
  a_swap: assert property (p_swap) else $error("nibble swap wrong");

  property p_pair;
    ex1 && op == OP_COPY_REGISTER_PAIR |=> idle && gpr_q[pair_d] == $past(gpr_q[pair_r]) &&
      gpr_q[pair_d + 5'h01] == $past(gpr_q[pair_r + 5'h01]);
  endproperty
  a_pair: assert property (p_pair) else $error("register pair copy wrong");

  c_taken:    cover property (ex1 && taken ##1 ex2);
  c_post_inc: cover property (ex2 && op == OP_LOAD_INDIRECT && ptr_upd == LDM_POST_INC);
  c_pre_dec:  cover property (ex2 && op == OP_LOAD_INDIRECT && ptr_upd == LDM_PRE_DEC);
  c_io_set:   cover property (ex2 && op == OP_IO_BIT_SET);
  c_rot_c:    cover property (ex1 && op == OP_ROTATE_LEFT_CARRY && flags_q[FLG_C]);
endmodule

// File: dv/cbf_wb_host.sv
`timescale 1ns/1ps
module cbf_wb_host
  import cbf_pkg::*;
(
  // Clock
  input  wire logic             clk_in,
  // Wishbone master side
  output logic                  cyc_out,
  output logic                  stb_out,
  output logic                  we_out,
  output logic [ADR_W-1:0]      adr_out,
  output logic [31:0]           dat_out,
  output logic [3:0]            sel_out,
  input  wire logic             ack_in,
  input  wire logic [31:0]      dat_in
);
  int n_late = 0;
  initial begin
    {cyc_out, stb_out, we_out, adr_out, dat_out, sel_out} = '0;
  end
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    int i;
    @(posedge clk_in);
    {cyc_out, stb_out, we_out} <= {2'b11, w};
    adr_out <= a;
    dat_out <= d;
    sel_out <= 4'hf;
    i = 0;
    do begin
      @(posedge clk_in);
      i++;
    end while (ack_in !== 1'b1 && i < 20);
    if (ack_in !== 1'b1) n_late++;
    q = dat_in;
    {cyc_out, stb_out} <= 2'b00;
    // Released address and data lines do not keep the old value
    adr_out <= ~a;
    dat_out <= ~d;
  endtask
endmodule

// File: dv/test_cpu_bit_flag_load_ops.sv
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_mismatch++; \
  $display("BAD %0t got %h want %h", $time, (a), (b)); end end
module test_cpu_bit_flag_load_ops;
  import cbf_pkg::*;
  typedef struct packed {
    logic [15:0] ins;
    logic [7:0]  f, v, ev, ef;
    logic [1:0]  ec;
  } cbf_row_t;
  localparam cbf_row_t ROWS [9] = '{
    '{16'h2803, 8'h30, 8'h81, 8'h02, 8'h39, 2'h1},
    '{16'h3003, 8'h00, 8'h81, 8'h40, 8'h09, 2'h1},
    '{16'h3803, 8'h00, 8'h81, 8'hc0, 8'h05, 2'h1},
    '{16'h4003, 8'h01, 8'h80, 8'h01, 8'h09, 2'h1},
    '{16'h4803, 8'h00, 8'h01, 8'h00, 8'h0b, 2'h1},
    '{16'h5003, 8'h35, 8'h3c, 8'hc3, 8'h35, 2'h1},
    '{16'h681f, 8'h00, 8'h80, 8'h80, 8'h40, 2'h1},
    '{16'h7018, 8'h40, 8'h00, 8'h01, 8'h40, 2'h1},
    '{16'h5003, 8'h00, 8'h00, 8'h00, 8'h00, 2'h1}
  };
  logic core_clk_in = 0, nrst_in = 0, wb_cyc_in, wb_stb_in, wb_we_in, wb_ack_out, busy_out;
  logic [ADR_W-1:0] wb_adr_in;
  logic [31:0]      wb_dat_in, wb_dat_out, rd_q;
  logic [3:0]       wb_sel_in;
  logic [7:0]       io_port0_out;
  int n_mismatch = 0, checks_done = 0;
  always #20 core_clk_in = ~core_clk_in;
  cbf_core_top dut (.core_clk_in(core_clk_in), .nrst_in(nrst_in), .wb_cyc_in(wb_cyc_in),
    .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in), .wb_dat_in(wb_dat_in),
    .wb_sel_in(wb_sel_in), .wb_ack_out(wb_ack_out), .wb_dat_out(wb_dat_out),
    .busy_out(busy_out), .io_port0_out(io_port0_out));
  cbf_wb_host host (.clk_in(core_clk_in), .cyc_out(wb_cyc_in), .stb_out(wb_stb_in),
    .we_out(wb_we_in), .adr_out(wb_adr_in), .dat_out(wb_dat_in), .sel_out(wb_sel_in),
    .ack_in(wb_ack_out), .dat_in(wb_dat_out));
  task automatic complete_run();
    n_mismatch += host.n_late;
    if (n_mismatch == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, rd_q);
    if (host.n_late != 0) complete_run();
  endtask
  task automatic rd(input logic [7:0] a);
    host.xfer(1'b0, a, 32'h0, rd_q);
    if (host.n_late != 0) complete_run();
  endtask
  task automatic setr(input logic [7:0] r, input logic [7:0] v);
    wr(ADR_IDX, {24'h0, r});
    wr(ADR_GPR, {24'h0, v});
  endtask
  task automatic getr(input logic [7:0] r);
    wr(ADR_IDX, {24'h0, r});
    rd(ADR_GPR);
  endtask
  task automatic run(input logic [15:0] ins);
    wr(ADR_INSTR, {16'h0, ins});
    idle_wait();
  endtask
  // Leaves STATUS in rd_q once the core is idle again
  task automatic idle_wait();
    int i;
    i = 0;
    do begin
      rd(ADR_STATUS);
      i++;
    end while (rd_q[STAT_BUSY_BIT] !== 1'b0 && i < 8);
    if (rd_q[STAT_BUSY_BIT] !== 1'b0) begin
      n_mismatch++;
      complete_run();
    end
    `CHK(busy_out, 1'b0)
  endtask
  task automatic br(input logic [15:0] ins, input logic [7:0] f, input logic [11:0] pc,
                    input logic [1:0] c);
    wr(ADR_PC, 32'h10);
    wr(ADR_FLAGS, {24'h0, f});
    run(ins);
    `CHK(rd_q[STAT_CYC_LSB+:2], c)
    rd(ADR_PC);
    `CHK(rd_q[11:0], pc)
    rd(ADR_FLAGS);
    `CHK(rd_q[7:0], f)
  endtask
  initial begin
    repeat (6) @(posedge core_clk_in);
    nrst_in <= 1'b1;
    rd(ADR_FLAGS);
    `CHK(rd_q, 32'h0)
    `CHK(io_port0_out, IO_RST)
    foreach (ROWS[r]) begin
      wr(ADR_FLAGS, {24'h0, ROWS[r].f});
      setr(8'h03, ROWS[r].v);
      run(ROWS[r].ins);
      `CHK(rd_q[STAT_CYC_LSB+:2], ROWS[r].ec)
      getr(8'h03);
      `CHK(rd_q[7:0], ROWS[r].ev)
      rd(ADR_FLAGS);
      `CHK(rd_q[7:0], ROWS[r].ef)
    end
    for (int s = 0; s < 8; s++) begin
      wr(ADR_FLAGS, 32'h0);
      run(16'h5800 | 16'(s));
      rd(ADR_FLAGS);
      `CHK(rd_q[7:0], 8'h01 << s)
      wr(ADR_FLAGS, 32'hff);
      run(16'h6000 | 16'(s));
      rd(ADR_FLAGS);
      `CHK(rd_q[7:0], ~(8'h01 << s))
    end
    br(16'h0805, 8'h80, 12'h016, 2'h2);
    br(16'h0805, 8'h00, 12'h011, 2'h1);
    br(16'h107e, 8'h00, 12'h00f, 2'h2);
    br(16'h107e, 8'h80, 12'h011, 2'h1);
    wr(ADR_IDX, 32'h0);
    wr(ADR_IO, 32'h5a);
    wr(ADR_INSTR, 32'h1800);
    // Mid-cycle look: a two-cycle op is still running after the ack
    @(negedge core_clk_in);
    `CHK(busy_out, 1'b1)
    idle_wait();
    `CHK(rd_q[STAT_CYC_LSB+:2], 2'h2)
    `CHK(io_port0_out, 8'h5b)
    run(16'h2003);
    `CHK(io_port0_out, 8'h53)
    setr(8'h1a, 8'h20);
    wr(ADR_IDX, 32'h20);
    wr(ADR_MEM, 32'ha5);
    run(16'h8045);
    `CHK(rd_q[STAT_CYC_LSB+:2], 2'h2)
    getr(8'h05);
    `CHK(rd_q[7:0], 8'ha5)
    getr(8'h1a);
    `CHK(rd_q[7:0], 8'h21)
    wr(ADR_IDX, 32'h21);
    wr(ADR_MEM, 32'h77);
    run(16'h8007);
    getr(8'h07);
    `CHK(rd_q[7:0], 8'h77)
    getr(8'h1a);
    `CHK(rd_q[7:0], 8'h21)
    setr(8'h1c, 8'h31);
    wr(ADR_IDX, 32'h30);
    wr(ADR_MEM, 32'h3c);
    run(16'h80a6);
    getr(8'h06);
    `CHK(rd_q[7:0], 8'h3c)
    getr(8'h1c);
    `CHK(rd_q[7:0], 8'h30)
    run(16'h785d);
    getr(8'h0a);
    `CHK(rd_q[7:0], 8'h21)
    // Reset lands while a two-cycle op is in flight
    wr(ADR_INSTR, 32'h1800);
    nrst_in <= 1'b0;
    @(posedge core_clk_in);
    `CHK(busy_out, 1'b0)
    `CHK(io_port0_out, IO_RST)
    `CHK(wb_ack_out, 1'b0)
    `CHK(wb_dat_out, 32'h0)
    nrst_in <= 1'b1;
    rd(ADR_PC);
    `CHK(rd_q, 32'h0)
    rd(8'h40);
    `CHK(rd_q, 32'h0)
    complete_run();
  end
endmodule
